/* hw/ccs_pkg.sv */
// shared constants and types for the calibration command sequencer
package ccs_pkg;
    localparam int CCS_DW = 16;
    localparam logic [CCS_DW-1:0] CCS_PASS_OPEN = 16'h0000;
    localparam logic [CCS_DW-1:0] CCS_PASS_RST = 16'h1234; // arbitrary default password
    localparam logic [CCS_DW-1:0] CCS_CONST_RST = 16'h0000;

    // command codes
    typedef enum logic [2:0] {
        CCS_CMD_MODE = 3'h0,
        CCS_CMD_MODE_QRY = 3'h1,
        CCS_CMD_SAVE = 3'h2,
        CCS_CMD_VPOINT = 3'h3,
        CCS_CMD_VDATA = 3'h4,
        CCS_CMD_OVTRIM = 3'h5
    } ccs_cmd_t;

    // error codes
    localparam logic [3:0] CCS_ERR_NONE = 4'h0;
    localparam logic [3:0] CCS_ERR_PASS = 4'h2;
    localparam logic [3:0] CCS_ERR_MODE = 4'h3;
    localparam logic [3:0] CCS_ERR_ORDER = 4'h6;
    localparam logic [3:0] CCS_ERR_STATE = 4'h7;

    // overvoltage trim duration
    localparam int CCS_TRIM_MS = 3000;
    localparam int CCS_CLK_MHZ = 250;
    localparam int CCS_TRIM_CYC = CCS_TRIM_MS * 1000 * CCS_CLK_MHZ;
endpackage

/* hw/ccs_vcal.sv */
// two-point voltage constant computation
`timescale 1ns/100ps
module ccs_vcal
    import ccs_pkg::*;
(
    input wire logic clk_i,                         // clock
    input wire logic nrst_i,                        // async reset, low
    input wire logic start_i,                       // both points entered
    input wire logic [ccs_pkg::CCS_DW-1:0] lo_i,    // low point reading
    input wire logic [ccs_pkg::CCS_DW-1:0] hi_i,    // high point reading
    output logic [ccs_pkg::CCS_DW-1:0] gain_o,      // computed gain
    output logic [ccs_pkg::CCS_DW-1:0] offset_o,    // computed offset
    output logic done_o                             // result valid pulse
);
    typedef struct packed {
        logic [CCS_DW-1:0] gain;
        logic [CCS_DW-1:0] offset;
        logic done;
    } ccs_vcal_st_t;

    ccs_vcal_st_t st_r, st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        if (start_i) begin
            st_nxt.gain = hi_i - lo_i;
            st_nxt.offset = lo_i;
            st_nxt.done = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign gain_o = st_r.gain;
    assign offset_o = st_r.offset;
    assign done_o = st_r.done;
endmodule

/* hw/ccs_top.sv */
// calibration command sequencer: mode gate, voltage two-point, save, overvoltage trim
`timescale 1ns/100ps
module ccs_top
    import ccs_pkg::*;
#(
    parameter int TRIM_CYC = ccs_pkg::CCS_TRIM_CYC  // overvoltage trim length
) (
    input wire logic clk_i,                             // clock 250 MHz
    input wire logic nrst_i,                            // async reset, low
    input wire logic cmd_valid_i,                       // command strobe
    input wire ccs_pkg::ccs_cmd_t cmd_i,                // command code
    input wire logic cmd_arg_i,                         // on/off or min/max
    input wire logic pass_given_i,                      // password present
    input wire logic [ccs_pkg::CCS_DW-1:0] data_i,      // password or reading
    output logic cmd_ready_o,                           // can take a command
    input wire logic output_on_i,                       // output enabled
    input wire logic volt_reg_i,                        // constant_voltage_regulation
    input wire logic [ccs_pkg::CCS_DW-1:0] trim_meas_i, // trim result source
    output logic cal_mode_o,                            // calibration mode flag
    output logic qry_valid_o,                           // query answer pulse
    output logic qry_data_o,                            // mode query answer
    output logic err_valid_o,                           // error pulse
    output logic [3:0] err_code_o,                      // error code
    output logic point_sel_o,                           // driven point sel (1 high)
    output logic point_drive_o,                         // output at cal point
    output logic trim_busy_o,                           // overvoltage trim running
    output logic [ccs_pkg::CCS_DW-1:0] nv_gain_o,       // stored voltage gain
    output logic [ccs_pkg::CCS_DW-1:0] nv_offset_o,     // stored voltage offset
    output logic [ccs_pkg::CCS_DW-1:0] nv_trim_o,       // stored trim constant
    output logic nv_write_o                             // stored set updated
);
    ////////////////////////////////////////////////////////////////////////////

    typedef enum logic [4:0] {
        CCS_S_IDLE = 5'b00001,
        CCS_S_LO_SEL = 5'b00010,
        CCS_S_LO_DONE = 5'b00100,
        CCS_S_HI_SEL = 5'b01000,
        CCS_S_TRIM = 5'b10000
    } ccs_state_t;

    typedef struct packed {
        ccs_state_t state;
        logic mode;
        logic [CCS_DW-1:0] pass;
        logic [CCS_DW-1:0] lo;
        logic [CCS_DW-1:0] hi;
        logic calc;
        logic [CCS_DW-1:0] wk_gain;
        logic [CCS_DW-1:0] wk_offset;
        logic wk_new;
        logic [CCS_DW-1:0] nv_gain;
        logic [CCS_DW-1:0] nv_offset;
        logic [CCS_DW-1:0] nv_trim;
        logic nv_write;
        logic [31:0] trim_cnt;
        logic qry_valid;
        logic qry_data;
        logic err_valid;
        logic [3:0] err_code;
        logic point_sel;
        logic point_drive;
    } ccs_st_t;

    ccs_st_t st_r, st_nxt;
    logic [CCS_DW-1:0] calc_gain, calc_offset;
    logic calc_done;

    ccs_vcal u_vcal (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .start_i(st_r.calc),
        .lo_i(st_r.lo),
        .hi_i(st_r.hi),
        .gain_o(calc_gain),
        .offset_o(calc_offset),
        .done_o(calc_done)
    );

    ////////////////////////////////////////////////////////////////////////////

    always_comb begin
        st_nxt = st_r;
        st_nxt.qry_valid = 1'b0;
        st_nxt.err_valid = 1'b0;
        st_nxt.nv_write = 1'b0;
        st_nxt.calc = 1'b0;
        if (calc_done && st_r.mode) begin // late result of a dropped session is ignored
            st_nxt.wk_gain = calc_gain;
            st_nxt.wk_offset = calc_offset;
            st_nxt.wk_new = 1'b1;
        end
        if (st_r.state == CCS_S_TRIM) begin
            // commands are held off by cmd_ready_o until the trim ends
            if (st_r.trim_cnt >= 32'(TRIM_CYC - 1)) begin
                st_nxt.nv_trim = trim_meas_i;
                st_nxt.nv_write = 1'b1;
                st_nxt.point_drive = 1'b0;
                st_nxt.state = CCS_S_IDLE;
            end else begin
                st_nxt.trim_cnt = st_r.trim_cnt + 32'h1;
            end
        end else if (cmd_valid_i) begin
            if (cmd_i == CCS_CMD_MODE) begin
                if (cmd_arg_i) begin
                    if (st_r.pass == CCS_PASS_OPEN
                            || (pass_given_i && data_i == st_r.pass)) begin
                        st_nxt.mode = 1'b1;
                    end else begin
                        st_nxt.err_valid = 1'b1;
                        st_nxt.err_code = CCS_ERR_PASS;
                    end
                end else begin
                    if (st_r.mode) begin
                        st_nxt.wk_gain = st_r.nv_gain;
                        st_nxt.wk_offset = st_r.nv_offset;
                        st_nxt.wk_new = 1'b0;
                    end
                    st_nxt.mode = 1'b0;
                    st_nxt.state = CCS_S_IDLE;
                    st_nxt.point_drive = 1'b0;
                end
            end else if (cmd_i == CCS_CMD_MODE_QRY) begin
                st_nxt.qry_valid = 1'b1;
                st_nxt.qry_data = st_r.mode;
            end else if (!st_r.mode) begin
                st_nxt.err_valid = 1'b1;
                st_nxt.err_code = CCS_ERR_MODE;
            end else begin
                case (cmd_i)
                    CCS_CMD_SAVE: begin
                        st_nxt.nv_gain = st_r.wk_gain;
                        st_nxt.nv_offset = st_r.wk_offset;
                        st_nxt.nv_write = 1'b1;
                        st_nxt.wk_new = calc_done && st_r.mode; // fresh result wins
                    end
                    CCS_CMD_VPOINT: begin
                        if (!cmd_arg_i) begin
                            st_nxt.state = CCS_S_LO_SEL;
                            st_nxt.point_sel = 1'b0;
                            st_nxt.point_drive = 1'b1;
                        end else if (st_r.state == CCS_S_LO_DONE) begin
                            st_nxt.state = CCS_S_HI_SEL;
                            st_nxt.point_sel = 1'b1;
                            st_nxt.point_drive = 1'b1;
                        end else begin
                            st_nxt.err_valid = 1'b1;
                            st_nxt.err_code = CCS_ERR_ORDER;
                        end
                    end
                    CCS_CMD_VDATA: begin
                        if (st_r.state == CCS_S_LO_SEL) begin
                            st_nxt.lo = data_i;
                            st_nxt.state = CCS_S_LO_DONE;
                        end else if (st_r.state == CCS_S_HI_SEL) begin
                            st_nxt.hi = data_i;
                            st_nxt.calc = 1'b1;
                            st_nxt.state = CCS_S_IDLE;
                            st_nxt.point_drive = 1'b0;
                        end else begin
                            st_nxt.err_valid = 1'b1;
                            st_nxt.err_code = CCS_ERR_ORDER;
                        end
                    end
                    CCS_CMD_OVTRIM: begin
                        if (!(output_on_i && volt_reg_i)) begin
                            st_nxt.err_valid = 1'b1;
                            st_nxt.err_code = CCS_ERR_STATE;
                        end else begin
                            st_nxt.state = CCS_S_TRIM;
                            st_nxt.trim_cnt = 32'h0;
                            st_nxt.point_drive = 1'b0;
                        end
                    end
                    default: begin
                        st_nxt.err_valid = 1'b1;
                        st_nxt.err_code = CCS_ERR_ORDER;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_r <= '0;
            st_r.state <= CCS_S_IDLE;
            st_r.pass <= CCS_PASS_RST;
            st_r.wk_gain <= CCS_CONST_RST;
            st_r.wk_offset <= CCS_CONST_RST;
            st_r.nv_gain <= CCS_CONST_RST;
            st_r.nv_offset <= CCS_CONST_RST;
            st_r.nv_trim <= CCS_CONST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    assign cmd_ready_o = (st_r.state != CCS_S_TRIM);
    assign cal_mode_o = st_r.mode;
    assign qry_valid_o = st_r.qry_valid;
    assign qry_data_o = st_r.qry_data;
    assign err_valid_o = st_r.err_valid;
    assign err_code_o = st_r.err_code;
    assign point_sel_o = st_r.point_sel;
    assign point_drive_o = st_r.point_drive;
    assign trim_busy_o = (st_r.state == CCS_S_TRIM);
    assign nv_gain_o = st_r.nv_gain;
    assign nv_offset_o = st_r.nv_offset;
    assign nv_trim_o = st_r.nv_trim;
    assign nv_write_o = st_r.nv_write;
endmodule

/* tb/ccs_props.sv */
// port checker for the calibration command sequencer
`timescale 1ns/100ps
module ccs_props
    import ccs_pkg::*;
#(
    parameter int TRIM_CYC = 20 // trim length
) (
    input wire logic clk_i, // clock
    input wire logic nrst_i, // reset, low
    input wire logic cmd_valid_i, // strobe
    input wire ccs_pkg::ccs_cmd_t cmd_i, // code
    input wire logic cmd_arg_i, // argument
    input wire logic pass_given_i, // password flag
    input wire logic [ccs_pkg::CCS_DW-1:0] data_i, // data
    input wire logic cmd_ready_o, // ready
    input wire logic output_on_i, // output on
    input wire logic volt_reg_i, // regulation
    input wire logic cal_mode_o, // mode flag
    input wire logic qry_valid_o, // answer pulse
    input wire logic qry_data_o, // answer
    input wire logic err_valid_o, // error pulse
    input wire logic [3:0] err_code_o, // error code
    input wire logic point_drive_o, // at point
    input wire logic point_sel_o, // point
    input wire logic trim_busy_o, // trim running
    input wire logic nv_write_o // store pulse
);
    logic tk;
    logic tkc;
    logic vp_r;
    int bcnt_r;
    assign tk = cmd_valid_i && cmd_ready_o;
    assign tkc = tk && cal_mode_o;
    // vp_r: a level command was taken in cal mode, accepted or not, since the last reading or disable
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            vp_r <= 1'b0;
            bcnt_r <= 0;
        end else begin
            bcnt_r <= trim_busy_o ? bcnt_r + 1 : 0;
            if (tkc && cmd_i == CCS_CMD_VPOINT) begin
                vp_r <= 1'b1;
            end else if (tk && (cmd_i == CCS_CMD_VDATA
                    || (cmd_i == CCS_CMD_MODE && !cmd_arg_i))) begin
                vp_r <= 1'b0;
            end
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    ////////////////////////////////////////////////////////////////////////////////
    property p_gate;
        tk && !cal_mode_o && cmd_i inside {CCS_CMD_SAVE, CCS_CMD_VPOINT, CCS_CMD_VDATA,
        CCS_CMD_OVTRIM} |=> err_valid_o && err_code_o == CCS_ERR_MODE && !nv_write_o;
    endproperty
    a_gate: assert property (p_gate) else $error("command taken with mode off");
    property p_pass;
        tk && !cal_mode_o && cmd_i == CCS_CMD_MODE && cmd_arg_i && (!pass_given_i ||
        data_i != CCS_PASS_RST) |=> err_valid_o && err_code_o == CCS_ERR_PASS && !cal_mode_o;
    endproperty
    a_pass: assert property (p_pass) else $error("bad password accepted");
    property p_qry;
        tk && cmd_i == CCS_CMD_MODE_QRY |=> qry_valid_o && qry_data_o == $past(cal_mode_o);
    endproperty
    a_qry: assert property (p_qry) else $error("query answer wrong");
    property p_order;
        tkc && cmd_i == CCS_CMD_VDATA && !vp_r |=> err_valid_o && err_code_o == CCS_ERR_ORDER;
    endproperty
    a_order: assert property (p_order) else $error("reading without level taken");
    property p_state;
        tkc && cmd_i == CCS_CMD_OVTRIM && !(output_on_i && volt_reg_i)
        |=> err_valid_o && err_code_o == CCS_ERR_STATE && !trim_busy_o;
    endproperty
    a_state: assert property (p_state) else $error("trim in wrong state");
    property p_trim;
        tkc && cmd_i == CCS_CMD_OVTRIM && output_on_i && volt_reg_i
        |=> (trim_busy_o && !cmd_ready_o) [*8];
    endproperty
    a_trim: assert property (p_trim) else $error("trim not holding commands");
    property p_tend;
        $fell(trim_busy_o) |-> nv_write_o && bcnt_r == TRIM_CYC;
    endproperty
    a_tend: assert property (p_tend) else $error("trim end wrong");
    property p_point;
        tkc && cmd_i == CCS_CMD_VPOINT && !cmd_arg_i |=> point_drive_o && !point_sel_o;
    endproperty
    a_point: assert property (p_point) else $error("low point not driven");
endmodule
bind ccs_top ccs_props #(.TRIM_CYC(TRIM_CYC)) ccs_props_inst (
    .clk_i(clk_i), .nrst_i(nrst_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
    .cmd_arg_i(cmd_arg_i), .pass_given_i(pass_given_i), .data_i(data_i),
    .cmd_ready_o(cmd_ready_o), .output_on_i(output_on_i), .volt_reg_i(volt_reg_i),
    .cal_mode_o(cal_mode_o), .qry_valid_o(qry_valid_o), .qry_data_o(qry_data_o),
    .err_valid_o(err_valid_o), .err_code_o(err_code_o), .point_drive_o(point_drive_o),
    .point_sel_o(point_sel_o), .trim_busy_o(trim_busy_o), .nv_write_o(nv_write_o)
);

/* tb/ccs_ctrl_model.sv */
// remote controller model issuing calibration commands
`timescale 1ns/100ps
module ccs_ctrl_model
    import ccs_pkg::*;
(
    input wire logic clk_i, // clock
    input wire logic rdy_i, // device ready
    output logic valid_o, // strobe
    output ccs_pkg::ccs_cmd_t cmd_o, // code
    output logic arg_o, // argument
    output logic pass_o, // password flag
    output logic [ccs_pkg::CCS_DW-1:0] data_o // data
);
    initial begin
        valid_o = 1'b0;
        cmd_o = CCS_CMD_MODE_QRY;
        arg_o = 1'b0;
        pass_o = 1'b0;
        data_o = 16'h0000;
    end
    // holds a command for up to 200 cycles until taken, so a running trim is waited out; no relay exists here
    task automatic issue(input ccs_cmd_t c, input logic a, input logic p,
        input logic [CCS_DW-1:0] d, output logic ok);
        @(posedge clk_i);
        valid_o <= 1'b1;
        cmd_o <= c;
        arg_o <= a;
        pass_o <= p;
        data_o <= d;
        ok = 1'b0;
        for (int i = 0; i < 200 && !ok; i++) begin
            @(negedge clk_i);
            ok = (rdy_i === 1'b1);
            @(posedge clk_i);
        end
        valid_o <= 1'b0;
        data_o <= ~d;
    endtask
endmodule

/* tb/tb.sv */
// self-checking bench for the calibration command sequencer
`timescale 1ns/100ps
module tb;
    import ccs_pkg::*;
    localparam int TC = 20;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic out_on = 1'b0;
    logic volt_reg = 1'b0;
    logic [15:0] trim_src = 16'h0000;
    logic v, a, p, ready, cal, qv, qd, ev, psel, pdrv, busy, nw;
    ccs_cmd_t c;
    logic [15:0] d, ng, no, ntr;
    logic [3:0] ec;
    int n_errors = 0;
    int checks_done = 0;
    int cyc = 0;
    int n;
    always #2 clk_i = ~clk_i;
    ccs_ctrl_model ccs_ctrl_model_inst (.clk_i(clk_i), .rdy_i(ready), .valid_o(v), .cmd_o(c),
        .arg_o(a), .pass_o(p), .data_o(d));
    ccs_top #(.TRIM_CYC(TC)) ccs_top_inst (.clk_i(clk_i), .nrst_i(nrst_i), .cmd_valid_i(v),
        .cmd_i(c), .cmd_arg_i(a), .pass_given_i(p), .data_i(d), .cmd_ready_o(ready),
        .output_on_i(out_on), .volt_reg_i(volt_reg), .trim_meas_i(trim_src), .cal_mode_o(cal),
        .qry_valid_o(qv), .qry_data_o(qd), .err_valid_o(ev), .err_code_o(ec),
        .point_sel_o(psel), .point_drive_o(pdrv), .trim_busy_o(busy), .nv_gain_o(ng),
        .nv_offset_o(no), .nv_trim_o(ntr), .nv_write_o(nw));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // result pulses are looked at in the cycle after the taking edge
    task automatic send(input ccs_cmd_t cc, input logic aa, input logic pp, input logic [15:0] dd);
        logic ok;
        ccs_ctrl_model_inst.issue(cc, aa, pp, dd, ok);
        chk(16'(ok), 16'h1);
        @(negedge clk_i);
    endtask
    task automatic err(input ccs_cmd_t cc, input logic aa, input logic pp, input logic [15:0] dd,
        input logic [3:0] e);
        send(cc, aa, pp, dd);
        chk(16'(ev), 16'h1);
        chk(16'(ec), 16'(e));
    endtask
    task automatic vcal(input logic [15:0] lo, input logic [15:0] hi);
        send(CCS_CMD_VPOINT, 1'b0, 1'b0, 16'h0);
        chk(16'(pdrv), 16'h1);
        chk(16'(psel), 16'h0);
        send(CCS_CMD_VDATA, 1'b0, 1'b0, lo);
        send(CCS_CMD_VPOINT, 1'b1, 1'b0, 16'h0);
        chk(16'(psel), 16'h1);
        send(CCS_CMD_VDATA, 1'b0, 1'b0, hi);
    endtask
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            close_out();
        end
    end
    initial begin
        repeat (10) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(negedge clk_i);
        chk({cal, ready, 14'h0}, 16'h4000);
        for (int k = 2; k < 6; k++) begin
            err(ccs_cmd_t'(k), 1'b0, 1'b0, 16'h0, CCS_ERR_MODE);
        end
        err(CCS_CMD_MODE, 1'b1, 1'b0, CCS_PASS_RST, CCS_ERR_PASS);
        err(CCS_CMD_MODE, 1'b1, 1'b1, ~CCS_PASS_RST, CCS_ERR_PASS);
        send(CCS_CMD_MODE_QRY, 1'b0, 1'b0, 16'h0);
        chk({qv, qd, cal}, 16'h4);
        send(CCS_CMD_MODE, 1'b1, 1'b1, CCS_PASS_RST);
        send(CCS_CMD_MODE_QRY, 1'b0, 1'b0, 16'h0);
        chk({qv, qd, cal}, 16'h7);
        err(CCS_CMD_VDATA, 1'b0, 1'b0, 16'h5, CCS_ERR_ORDER);
        err(CCS_CMD_VPOINT, 1'b1, 1'b0, 16'h0, CCS_ERR_ORDER);
        vcal(16'h0100, 16'h0900);
        repeat (3) @(negedge clk_i);
        chk(ng, CCS_CONST_RST);
        send(CCS_CMD_SAVE, 1'b0, 1'b0, 16'h0);
        chk(16'(nw), 16'h1);
        chk(ng, 16'h0800);
        chk(no, 16'h0100);
        vcal(16'h0200, 16'h0300); // disable below lands in the same cycle as this result and overrides it
        send(CCS_CMD_MODE, 1'b0, 1'b0, 16'h0);
        send(CCS_CMD_MODE, 1'b1, 1'b1, CCS_PASS_RST);
        send(CCS_CMD_SAVE, 1'b0, 1'b0, 16'h0);
        chk(ng, 16'h0800);
        chk(no, 16'h0100);
        err(CCS_CMD_OVTRIM, 1'b0, 1'b0, 16'h0, CCS_ERR_STATE);
        @(posedge clk_i);
        out_on <= 1'b1;
        err(CCS_CMD_OVTRIM, 1'b0, 1'b0, 16'h0, CCS_ERR_STATE);
        @(posedge clk_i);
        volt_reg <= 1'b1;
        trim_src <= 16'h0abc;
        send(CCS_CMD_OVTRIM, 1'b0, 1'b0, 16'h0);
        chk({busy, ready}, 16'h2);
        n = 1;
        while (nw !== 1'b1 && n < 100) begin
            @(negedge clk_i);
            n++;
        end
        chk(16'(n), 16'(TC + 1));
        chk(ntr, 16'h0abc);
        chk(ng, 16'h0800);
        close_out();
    end
endmodule
